// >>> gpz_pkg.sv
// Shared constants for the port-zero pin control block
package gpz_pkg;

	// ==========================================================
	// Widths
	localparam int GPZ_PORT_W = 8;
	localparam int GPZ_ADR_W = 5;
	localparam int GPZ_DAT_W = 32;
	localparam int GPZ_SEL_W = 4;
	localparam int GPZ_CMP_W = 4;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [GPZ_ADR_W-1:0] GPZ_OFS_DATA = 5'h00;
	localparam logic [GPZ_ADR_W-1:0] GPZ_OFS_DIR = 5'h04;
	localparam logic [GPZ_ADR_W-1:0] GPZ_OFS_PULL = 5'h08;
	localparam logic [GPZ_ADR_W-1:0] GPZ_OFS_AIDR = 5'h0C;
	localparam logic [GPZ_ADR_W-1:0] GPZ_OFS_STBY = 5'h10;
	localparam logic [GPZ_ADR_W-1:0] GPZ_OFS_CMPA = 5'h14;
	localparam logic [GPZ_ADR_W-1:0] GPZ_OFS_CMPB = 5'h18;
	localparam logic [GPZ_ADR_W-1:0] GPZ_OFS_RMW = 5'h1C;
	localparam int GPZ_WORD_LSB = 2;

	// ==========================================================
	// Reset values
	localparam logic [GPZ_PORT_W-1:0] GPZ_RST_BYTE = 8'h00;
	localparam logic [GPZ_DAT_W-1:0] GPZ_RST_WORD = 32'h0000_0000;

	// ==========================================================
	// Field positions
	localparam int GPZ_SPL_BIT = 0;
	localparam int GPZ_COMPARATOR_ANALOG_ENABLE_N_BIT = 0;
	localparam int GPZ_NEGATIVE_SOURCE_SELECT_BIT = 1;
	localparam int GPZ_LANE0 = 0;

	// ==========================================================
	// Comparator pin positions
	localparam int GPZ_CMPA_P_PIN = 0;
	localparam int GPZ_CMPA_N_PIN = 1;
	localparam int GPZ_CMPB_P_PIN = 3;
	localparam int GPZ_CMPB_N_PIN = 4;

endpackage : gpz_pkg

// >>> gpz_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module gpz_sync import gpz_pkg::*; #(
	parameter int W = GPZ_PORT_W
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	// ==========================================================
	// First stage feeds only the second stage
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= '0;
			q_ff <= '0;
		end else if (ce) begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end

	assign q = q_ff;

endmodule : gpz_sync

// >>> gpz_cmp_gate.sv
// Comparator analog input enables for the four comparator pins
`timescale 1ns/1ps
module gpz_cmp_gate import gpz_pkg::*; (
	// Comparator controls
	input wire logic [GPZ_PORT_W-1:0] comparator_a_control,
	input wire logic [GPZ_PORT_W-1:0] comparator_b_control,
	input wire logic [GPZ_PORT_W-1:0] analog_input_disable_low,
	// Enables, order: a_pos, a_neg, b_pos, b_neg
	output logic [GPZ_CMP_W-1:0] cmp_en
);

	logic comparator_analog_enable_n_a_n;
	logic comparator_analog_enable_n_b_n;

	assign comparator_analog_enable_n_a_n = comparator_a_control[GPZ_COMPARATOR_ANALOG_ENABLE_N_BIT];
	assign comparator_analog_enable_n_b_n = comparator_b_control[GPZ_COMPARATOR_ANALOG_ENABLE_N_BIT];

	// ==========================================================
	// Positive inputs ignore data and direction; negative inputs also need source select low
	always_comb begin
		cmp_en[0] = !comparator_analog_enable_n_a_n && !analog_input_disable_low[GPZ_CMPA_P_PIN]; // RULE14
		cmp_en[1] = !comparator_analog_enable_n_a_n && !comparator_a_control[GPZ_NEGATIVE_SOURCE_SELECT_BIT]
			&& !analog_input_disable_low[GPZ_CMPA_N_PIN]; // RULE15
		cmp_en[2] = !comparator_analog_enable_n_b_n && !analog_input_disable_low[GPZ_CMPB_P_PIN]; // RULE14
		cmp_en[3] = !comparator_analog_enable_n_b_n && !comparator_b_control[GPZ_NEGATIVE_SOURCE_SELECT_BIT]
			&& !analog_input_disable_low[GPZ_CMPB_N_PIN]; // RULE15
	end

endmodule : gpz_cmp_gate

// >>> gpz_port.sv
// Port-zero pin control: registers, pin drive, input gating, standby
//
// Function
// RULE1: Software clears direction before peripheral input use.
// RULE2: Software sets analog disable for digital input.
// RULE3: Plain data read gives pins; RMW gives latch. Here output pins read the latch on a plain read too.
// RULE4: Reset clears all direction bits to input.
// RULE5: Reset clears analog disable, digital input off.
// RULE6: Standby with select set forces pins Hi-Z.
// RULE7: Forced standby holds pin inputs low, blocked.
// RULE8: Enabled external interrupt keeps its input open.
// RULE9: Standby with select clear holds outputs unchanged.
// RULE10: Analog use: software clears direction, disable, pull-up.
// RULE11: Pin level always reaches external interrupt circuit. Here forced standby holds it low unless that interrupt is enabled.
// RULE12: Software disables unused interrupt, clears direction.
// RULE13: Pull-up on by bit, off when driving low.
// RULE14: Positive comparator input enabled while enable bit zero. Here the pin's analog disable bit must also be clear.
// RULE15: Negative comparator input needs both bits zero. Here the pin's analog disable bit must also be clear.
// RULE16: Output pins driven from latch; writes always latch.
// RULE17: Input pin write only latches; reads per type.
// RULE18: Register bit n belongs to pin n.
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module gpz_port import gpz_pkg::*; #(
	parameter int PORT_W = GPZ_PORT_W
) (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [GPZ_ADR_W-1:0] wb_adr_i,
	input wire logic [GPZ_SEL_W-1:0] wb_sel_i,
	input wire logic [GPZ_DAT_W-1:0] wb_dat_i,
	output logic [GPZ_DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// System state and neighbours
	input wire logic standby_active,
	input wire logic [PORT_W-1:0] ext_irq_en,
	input wire logic [PORT_W-1:0] periph_out_en,
	input wire logic [PORT_W-1:0] periph_out,
	// Pins
	input wire logic [PORT_W-1:0] pin_in,
	output logic [PORT_W-1:0] pin_out,
	output logic [PORT_W-1:0] pin_oe,
	output logic [PORT_W-1:0] pull_up_on,
	// Inputs toward peripherals
	output logic [PORT_W-1:0] periph_in,
	output logic [PORT_W-1:0] ext_irq_level,
	output logic [GPZ_CMP_W-1:0] cmp_in_en
);

	// ==========================================================
	// Helpers
	function automatic logic reg_hit(input logic [GPZ_ADR_W-1:0] adr,
		input logic [GPZ_ADR_W-1:0] ofs);
		reg_hit = adr[GPZ_ADR_W-1:GPZ_WORD_LSB] == ofs[GPZ_ADR_W-1:GPZ_WORD_LSB];
	endfunction : reg_hit

	function automatic logic [GPZ_PORT_W-1:0] wr_byte(input logic [GPZ_PORT_W-1:0] old,
		input logic [GPZ_DAT_W-1:0] dat, input logic lane);
		wr_byte = lane ? dat[GPZ_PORT_W-1:0] : old;
	endfunction : wr_byte

	// ==========================================================
	// Declarations
	logic [PORT_W-1:0] port_data_latch_ff;
	logic [PORT_W-1:0] port_direction_bits_ff;
	logic [PORT_W-1:0] pull_up_enable_bits_ff;
	logic [PORT_W-1:0] analog_input_disable_low_ff;
	logic [GPZ_PORT_W-1:0] standby_control_ff;
	logic [GPZ_PORT_W-1:0] comparator_a_control_ff;
	logic [GPZ_PORT_W-1:0] comparator_b_control_ff;
	logic [PORT_W-1:0] pin_out_ff;
	logic [PORT_W-1:0] pin_oe_ff;
	logic [PORT_W-1:0] periph_in_ff;
	logic [PORT_W-1:0] ext_irq_level_ff;
	logic [GPZ_DAT_W-1:0] wb_dat_ff;
	logic wb_ack_ff;
	logic [PORT_W-1:0] pin_sync;
	logic [PORT_W-1:0] blocked;
	logic [PORT_W-1:0] drive_en;
	logic [PORT_W-1:0] drive_val;
	logic [PORT_W-1:0] pin_view;
	logic [PORT_W-1:0] nxt_pin_out;
	logic [PORT_W-1:0] nxt_pin_oe;
	logic [PORT_W-1:0] nxt_rd;
	logic standby_pin_hiz_select;
	logic hiz_active;
	logic bus_req;
	logic wr_en;
	logic lane0;

	// ==========================================================
	// Pin synchroniser
	gpz_sync #(
		.W(PORT_W)
	) u_sync (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.ce(ce),
		.d(pin_in),
		.q(pin_sync)
	);

	// ==========================================================
	// Bus decode
	// A new request is taken only while ack is low, so each access acts once
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_ff && ce;
	assign wr_en = bus_req && wb_we_i;
	assign lane0 = wb_sel_i[GPZ_LANE0];

	// ==========================================================
	// Output latch: every write lands whatever the direction
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			port_data_latch_ff <= GPZ_RST_BYTE;
		end else if (wr_en && (reg_hit(wb_adr_i, GPZ_OFS_DATA) || reg_hit(wb_adr_i, GPZ_OFS_RMW))) begin
			port_data_latch_ff <= wr_byte(port_data_latch_ff, wb_dat_i, lane0); // RULE16 RULE17 RULE18
		end
	end

	// ==========================================================
	// Direction
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			port_direction_bits_ff <= GPZ_RST_BYTE; // RULE4
		end else if (wr_en && reg_hit(wb_adr_i, GPZ_OFS_DIR)) begin
			port_direction_bits_ff <= wr_byte(port_direction_bits_ff, wb_dat_i, lane0);
		end
	end

	// ==========================================================
	// Pull-up enables
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pull_up_enable_bits_ff <= GPZ_RST_BYTE;
		end else if (wr_en && reg_hit(wb_adr_i, GPZ_OFS_PULL)) begin
			pull_up_enable_bits_ff <= wr_byte(pull_up_enable_bits_ff, wb_dat_i, lane0);
		end
	end

	// ==========================================================
	// Analog input disable
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			analog_input_disable_low_ff <= GPZ_RST_BYTE; // RULE5
		end else if (wr_en && reg_hit(wb_adr_i, GPZ_OFS_AIDR)) begin
			analog_input_disable_low_ff <= wr_byte(analog_input_disable_low_ff, wb_dat_i, lane0);
		end
	end

	// ==========================================================
	// Standby and comparator controls
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			standby_control_ff <= GPZ_RST_BYTE;
			comparator_a_control_ff <= GPZ_RST_BYTE;
			comparator_b_control_ff <= GPZ_RST_BYTE;
		end else if (wr_en) begin
			if (reg_hit(wb_adr_i, GPZ_OFS_STBY)) begin
				standby_control_ff <= wr_byte(standby_control_ff, wb_dat_i, lane0);
			end
			if (reg_hit(wb_adr_i, GPZ_OFS_CMPA)) begin
				comparator_a_control_ff <= wr_byte(comparator_a_control_ff, wb_dat_i, lane0);
			end
			if (reg_hit(wb_adr_i, GPZ_OFS_CMPB)) begin
				comparator_b_control_ff <= wr_byte(comparator_b_control_ff, wb_dat_i, lane0);
			end
		end
	end

	assign standby_pin_hiz_select = standby_control_ff[GPZ_SPL_BIT];
	assign hiz_active = standby_active && standby_pin_hiz_select;

	// ==========================================================
	// Input gating
	// Enabled interrupt pins stay open in standby so they can wake the device
	assign blocked = hiz_active ? ~ext_irq_en : GPZ_RST_BYTE; // RULE7 RULE8
	// Peripheral-driven pins read back the pin; plain inputs need the analog disable set
	assign pin_view = pin_sync & ~blocked & (analog_input_disable_low_ff | periph_out_en);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			periph_in_ff <= GPZ_RST_BYTE;
			ext_irq_level_ff <= GPZ_RST_BYTE;
		end else if (ce) begin
			periph_in_ff <= pin_sync & analog_input_disable_low_ff & ~blocked; // RULE5 RULE7
			ext_irq_level_ff <= pin_sync & ~blocked; // RULE11 RULE8
		end
	end

	// ==========================================================
	// Pin drive
	assign drive_en = port_direction_bits_ff | periph_out_en;
	assign drive_val = (periph_out_en & periph_out) | (~periph_out_en & port_data_latch_ff);

	always_comb begin
		if (hiz_active) begin
			nxt_pin_oe = GPZ_RST_BYTE; // RULE6
			nxt_pin_out = pin_out_ff;
		end else if (standby_active) begin
			nxt_pin_oe = pin_oe_ff; // RULE9
			nxt_pin_out = pin_out_ff;
		end else begin
			nxt_pin_oe = drive_en; // RULE16 RULE17
			nxt_pin_out = drive_val;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pin_oe_ff <= GPZ_RST_BYTE;
			pin_out_ff <= GPZ_RST_BYTE;
		end else if (ce) begin
			pin_oe_ff <= nxt_pin_oe;
			pin_out_ff <= nxt_pin_out;
		end
	end

	// ==========================================================
	// Read path
	// Output pins give the latch; others show the synced pin, zero if blocked or if analog disable and periph_out_en are both clear
	always_comb begin
		nxt_rd = GPZ_RST_BYTE;
		if (reg_hit(wb_adr_i, GPZ_OFS_DATA)) begin
			nxt_rd = (port_direction_bits_ff & ~periph_out_en & port_data_latch_ff)
				| (~(port_direction_bits_ff & ~periph_out_en) & pin_view); // RULE3 RULE17
		end else if (reg_hit(wb_adr_i, GPZ_OFS_RMW)) begin
			nxt_rd = port_data_latch_ff; // RULE3
		end else if (reg_hit(wb_adr_i, GPZ_OFS_DIR)) begin
			nxt_rd = port_direction_bits_ff;
		end else if (reg_hit(wb_adr_i, GPZ_OFS_PULL)) begin
			nxt_rd = pull_up_enable_bits_ff;
		end else if (reg_hit(wb_adr_i, GPZ_OFS_AIDR)) begin
			nxt_rd = analog_input_disable_low_ff;
		end else if (reg_hit(wb_adr_i, GPZ_OFS_STBY)) begin
			nxt_rd = standby_control_ff;
		end else if (reg_hit(wb_adr_i, GPZ_OFS_CMPA)) begin
			nxt_rd = comparator_a_control_ff;
		end else if (reg_hit(wb_adr_i, GPZ_OFS_CMPB)) begin
			nxt_rd = comparator_b_control_ff;
		end
	end

	// ==========================================================
	// Bus answer: one wait state, data bits above the port width read as zero
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wb_ack_ff <= 1'b0;
			wb_dat_ff <= GPZ_RST_WORD;
		end else if (ce) begin
			wb_ack_ff <= bus_req;
			if (bus_req && !wb_we_i) begin
				wb_dat_ff <= {{(GPZ_DAT_W-GPZ_PORT_W){1'b0}}, nxt_rd};
			end
		end
	end

	// ==========================================================
	// Comparator enables
	gpz_cmp_gate u_cmp (
		.comparator_a_control(comparator_a_control_ff),
		.comparator_b_control(comparator_b_control_ff),
		.analog_input_disable_low(analog_input_disable_low_ff),
		.cmp_en(cmp_in_en)
	);

	// ==========================================================
	// Outputs
	assign pin_out = pin_out_ff;
	assign pin_oe = pin_oe_ff;
	// Pull-up is cut while the pin drives low, even if enabled
	assign pull_up_on = pull_up_enable_bits_ff & ~(pin_oe_ff & ~pin_out_ff); // RULE13
	assign periph_in = periph_in_ff;
	assign ext_irq_level = ext_irq_level_ff;
	assign wb_dat_o = wb_dat_ff;
	assign wb_ack_o = wb_ack_ff;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	dir_reset_a: assert property ($rose(nrst) |-> port_direction_bits_ff == GPZ_RST_BYTE) // RULE4
		else $error("direction not cleared by reset");
	aidr_reset_a: assert property ($rose(nrst) |-> analog_input_disable_low_ff == GPZ_RST_BYTE) // RULE5
		else $error("analog disable not cleared by reset");
	standby_hiz_a: assert property (ce && hiz_active |=> pin_oe == GPZ_RST_BYTE) // RULE6
		else $error("pin driven during forced standby");
	input_block_a: assert property (ce && hiz_active |=> (periph_in & ~$past(ext_irq_en)) == GPZ_RST_BYTE) // RULE7
		else $error("blocked input not held low");
	irq_open_a: assert property (ce && hiz_active |=>
		(ext_irq_level & $past(ext_irq_en)) == ($past(pin_sync) & $past(ext_irq_en))) // RULE8
		else $error("enabled interrupt input blocked in standby");
	standby_hold_a: assert property (ce && standby_active && !standby_pin_hiz_select |=>
		$stable(pin_oe) && $stable(pin_out)) // RULE9
		else $error("outputs changed in standby hold");
	pull_low_a: assert property ((pull_up_on & pin_oe & ~pin_out) == GPZ_RST_BYTE) // RULE13
		else $error("pull-up on while driving low");
	drive_a: assert property (ce && !standby_active |=> pin_oe == $past(drive_en)) // RULE16
		else $error("drive enable does not follow direction");
	rmw_read_a: assert property (bus_req && !wb_we_i && reg_hit(wb_adr_i, GPZ_OFS_RMW) |=>
		wb_ack_o && wb_dat_o[GPZ_PORT_W-1:0] == $past(port_data_latch_ff)) // RULE3
		else $error("rmw read did not return latch");
	latch_write_a: assert property (wr_en && lane0 && reg_hit(wb_adr_i, GPZ_OFS_DATA) |=>
		port_data_latch_ff == $past(wb_dat_i[GPZ_PORT_W-1:0])) // RULE17
		else $error("data write lost");
	cmp_pos_a: assert property (cmp_in_en[0] == (!comparator_a_control_ff[GPZ_COMPARATOR_ANALOG_ENABLE_N_BIT]
		&& !analog_input_disable_low_ff[GPZ_CMPA_P_PIN])) // RULE14
		else $error("positive comparator enable wrong");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held more than one cycle");

	// ==========================================================
	// Input paths
	// Analog-shared pins give peripherals nothing until the disable bit is set
	periph_gate_a: assert property (ce |=> // RULE5
		(periph_in & ~$past(analog_input_disable_low_ff)) == GPZ_RST_BYTE)
		else $error("peripheral input open with analog disable clear");
	irq_feed_a: assert property (ce && !hiz_active |=> ext_irq_level == $past(pin_sync)) // RULE11
		else $error("pin level not fed to interrupt circuit");

	// ==========================================================
	// Register and read-back behaviour
	dir_write_a: assert property (wr_en && lane0 && reg_hit(wb_adr_i, GPZ_OFS_DIR) |=> // RULE18
		port_direction_bits_ff == $past(wb_dat_i[GPZ_PORT_W-1:0]))
		else $error("direction write lost");
	// Output pins read back the latch, not the wire
	out_read_a: assert property (bus_req && !wb_we_i && reg_hit(wb_adr_i, GPZ_OFS_DATA) |=> // RULE3
		(wb_dat_o[GPZ_PORT_W-1:0] & $past(port_direction_bits_ff & ~periph_out_en))
		== $past(port_data_latch_ff & port_direction_bits_ff & ~periph_out_en))
		else $error("output pin read did not return latch");
	// A frozen clock enable must leave pins and latch untouched
	freeze_a: assert property (!ce |=>
		$stable(pin_oe) && $stable(pin_out) && $stable(port_data_latch_ff))
		else $error("state moved while clock enable low");

	// ==========================================================
	// Comparator enables
	cmp_neg_a: assert property (cmp_in_en[1] == (!comparator_a_control_ff[GPZ_COMPARATOR_ANALOG_ENABLE_N_BIT] // RULE15
		&& !comparator_a_control_ff[GPZ_NEGATIVE_SOURCE_SELECT_BIT] && !analog_input_disable_low_ff[GPZ_CMPA_N_PIN]))
		else $error("negative comparator enable wrong");
	cmp_b_pos_a: assert property (cmp_in_en[2] == (!comparator_b_control_ff[GPZ_COMPARATOR_ANALOG_ENABLE_N_BIT] // RULE14
		&& !analog_input_disable_low_ff[GPZ_CMPB_P_PIN]))
		else $error("second positive comparator enable wrong");
	cmp_b_neg_a: assert property (cmp_in_en[3] == (!comparator_b_control_ff[GPZ_COMPARATOR_ANALOG_ENABLE_N_BIT] // RULE15
		&& !comparator_b_control_ff[GPZ_NEGATIVE_SOURCE_SELECT_BIT] && !analog_input_disable_low_ff[GPZ_CMPB_N_PIN]))
		else $error("second negative comparator enable wrong");

	standby_hiz_c: cover property (ce && hiz_active ##1 ce && hiz_active);
	rmw_read_c: cover property (bus_req && !wb_we_i && reg_hit(wb_adr_i, GPZ_OFS_RMW));
	output_drive_c: cover property (ce && port_direction_bits_ff != GPZ_RST_BYTE ##1 pin_oe != GPZ_RST_BYTE);
	ce_freeze_c: cover property (!ce ##1 !ce);

endmodule : gpz_port

// >>> gpz_board.sv
// Board-side model of the eight port pins: wire resolution and external drivers
`timescale 1ns/1ps
module gpz_board import gpz_pkg::*; (
	// Clock
	input wire logic clk_sys,
	// Device side
	input wire logic [GPZ_PORT_W-1:0] pin_out,
	input wire logic [GPZ_PORT_W-1:0] pin_oe,
	input wire logic [GPZ_PORT_W-1:0] pull_up_on,
	// Board drivers
	input wire logic [GPZ_PORT_W-1:0] drv_en,
	input wire logic [GPZ_PORT_W-1:0] drv_val,
	// Resolved wire
	output logic [GPZ_PORT_W-1:0] pin_level
);
	// ==========================================================
	// Floating level
	logic [GPZ_PORT_W-1:0] float_ff = 8'h55;

	// A floating pin wanders, so no test may lean on its last value
	always_ff @(posedge clk_sys) begin
		float_ff <= ~float_ff;
	end

	// ==========================================================
	// Wire resolution
	always_comb begin
		for (int i = 0; i < GPZ_PORT_W; i++) begin
			if (pin_oe[i] && drv_en[i]) begin
				// Two drivers fight: the level is not defined
				pin_level[i] = 1'bx;
			end else if (pin_oe[i]) begin
				pin_level[i] = pin_out[i];
			end else if (drv_en[i]) begin
				pin_level[i] = drv_val[i];
			end else if (pull_up_on[i]) begin
				pin_level[i] = 1'b1;
			end else begin
				pin_level[i] = float_ff[i];
			end
		end
	end
endmodule : gpz_board

// >>> tb_gpz_port.sv
// Self-checking bench for the port-zero pin control block
`timescale 1ns/1ps
module tb_gpz_port import gpz_pkg::*;;
	// ==========================================================
	// Signals
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [GPZ_ADR_W-1:0] wb_adr_i = 5'h00;
	logic [GPZ_SEL_W-1:0] wb_sel_i = 4'h0;
	logic [GPZ_DAT_W-1:0] wb_dat_i = 32'h0000_0000;
	logic [GPZ_DAT_W-1:0] wb_dat_o;
	logic wb_ack_o;
	logic standby_active = 1'b0;
	logic [7:0] ext_irq_en = 8'h00;
	logic [7:0] periph_out_en = 8'h00;
	logic [7:0] periph_out = 8'h00;
	logic [7:0] pin_in;
	logic [7:0] pin_out;
	logic [7:0] pin_oe;
	logic [7:0] pull_up_on;
	logic [7:0] periph_in;
	logic [7:0] ext_irq_level;
	logic [GPZ_CMP_W-1:0] cmp_in_en;
	logic [7:0] drv_en = 8'h00;
	logic [7:0] drv_val = 8'h00;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;

	always #50 clk_sys = ~clk_sys;

	gpz_port #(.PORT_W(8)) gpz_port_inst (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.standby_active(standby_active), .ext_irq_en(ext_irq_en),
		.periph_out_en(periph_out_en), .periph_out(periph_out), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .pull_up_on(pull_up_on),
		.periph_in(periph_in), .ext_irq_level(ext_irq_level), .cmp_in_en(cmp_in_en));

	gpz_board gpz_board_inst (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
		.pull_up_on(pull_up_on), .drv_en(drv_en), .drv_val(drv_val), .pin_level(pin_in));

	// ==========================================================
	// Tasks
	task automatic conclude;
		$display("Checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Classic single cycle; held until ack is sampled high
	task automatic wb_xfer(input logic we, input logic [GPZ_ADR_W-1:0] adr,
		input logic [7:0] dat, output logic [7:0] rd);
		int n;
		n = 0;
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hF;
		wb_dat_i <= {24'h000000, dat};
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (wb_ack_o !== 1'b1) begin
			mismatches++;
			$display("MISMATCH t=%0t no bus answer", $time);
		end
		rd = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb_xfer

	task automatic wr(input logic [GPZ_ADR_W-1:0] adr, input logic [7:0] dat);
		logic [7:0] d;
		wb_xfer(1'b1, adr, dat, d);
	endtask : wr

	task automatic rd_chk(input logic [GPZ_ADR_W-1:0] adr, input logic [7:0] exp);
		logic [7:0] d;
		wb_xfer(1'b0, adr, 8'h00, d);
		chk(d, exp);
	endtask : rd_chk

	// Pin inputs pass two sync flops and a register, so wait them out
	task automatic board(input logic [7:0] en, input logic [7:0] val);
		@(posedge clk_sys);
		drv_en <= en;
		drv_val <= val;
		repeat (6) @(posedge clk_sys);
	endtask : board

	function automatic logic [7:0] cmp_exp(input logic [1:0] a, input logic [1:0] b);
		return {4'h0, ~b[0] & ~b[1], ~b[0], ~a[0] & ~a[1], ~a[0]};
	endfunction : cmp_exp

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			conclude();
		end
	end

	// ==========================================================
	// Test sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		chk(pin_oe, 8'h00);
		chk({4'h0, cmp_in_en}, 8'h0F);
		for (int i = 1; i < 8; i++) begin
			rd_chk(5'(i * 4), 8'h00);
		end
		wr(GPZ_OFS_DIR, 8'h00);
		wr(GPZ_OFS_DATA, 8'hA5);
		board(8'hFF, 8'h3C);
		chk(pin_oe, 8'h00);
		rd_chk(GPZ_OFS_RMW, 8'hA5);
		rd_chk(GPZ_OFS_DATA, 8'h00);
		chk(periph_in, 8'h00);
		chk(ext_irq_level, 8'h3C);
		wr(GPZ_OFS_AIDR, 8'hFF);
		board(8'hFF, 8'h3C);
		rd_chk(GPZ_OFS_DATA, 8'h3C);
		chk(periph_in, 8'h3C);
		for (int i = 0; i < 8; i++) begin
			board(8'hFF, 8'h01 << i);
			rd_chk(GPZ_OFS_DATA, 8'h01 << i);
		end
		// Output pins: board releases them first to avoid a fight
		board(8'h0F, 8'h3C);
		wr(GPZ_OFS_DIR, 8'hF0);
		board(8'h0F, 8'h3C);
		chk(pin_oe, 8'hF0);
		chk(pin_out & 8'hF0, 8'hA0);
		rd_chk(GPZ_OFS_DATA, 8'hAC);
		wr(GPZ_OFS_PULL, 8'hFF);
		chk(pull_up_on, 8'hAF);
		// Standby with the select bit clear keeps the outputs as they were
		@(posedge clk_sys);
		standby_active <= 1'b1;
		wr(GPZ_OFS_DATA, 8'h5A);
		board(8'h0F, 8'h3C);
		chk(pin_oe, 8'hF0);
		chk(pin_out & 8'hF0, 8'hA0);
		rd_chk(GPZ_OFS_RMW, 8'h5A);
		@(posedge clk_sys);
		standby_active <= 1'b0;
		board(8'h0F, 8'h3C);
		chk(pin_out & 8'hF0, 8'h50);
		// Forced high impedance, interrupt pins 0 and 7 stay open
		wr(GPZ_OFS_STBY, 8'h01);
		@(posedge clk_sys);
		ext_irq_en <= 8'h81;
		standby_active <= 1'b1;
		board(8'hFF, 8'hFF);
		chk(pin_oe, 8'h00);
		chk(periph_in, 8'h81);
		chk(ext_irq_level, 8'h81);
		rd_chk(GPZ_OFS_DATA, 8'h51);
		board(8'h0F, 8'h3C);
		@(posedge clk_sys);
		standby_active <= 1'b0;
		ext_irq_en <= 8'h00;
		// Comparator enables over every control setting
		wr(GPZ_OFS_AIDR, 8'h00);
		wr(GPZ_OFS_PULL, 8'h00);
		for (int v = 0; v < 4; v++) begin
			wr(GPZ_OFS_CMPA, 8'(v));
			wr(GPZ_OFS_CMPB, 8'(3 - v));
			chk({4'h0, cmp_in_en}, cmp_exp(2'(v), 2'(3 - v)));
		end
		wr(GPZ_OFS_CMPA, 8'h00);
		wr(GPZ_OFS_AIDR, 8'h1B);
		chk({4'h0, cmp_in_en}, 8'h00);
		// Clock enable low: only the pin drive enables are checked to stay frozen
		@(posedge clk_sys);
		ce <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk(pin_oe, 8'hF0);
		ce <= 1'b1;
		conclude();
	end
endmodule : tb_gpz_port
